// >>> hdl/dpm_priority_map.sv
// Overview of operation
// - bits 7:2 of the service octet decode into one of 64 codes
// - a 128-bit table of 2-bit fields; the selected field is the priority
// - IPv4 and IPv6 frames use the very same lookup
// - index 0x60 holds codes 0x00 to 0x03, lowest code in bits 1-0
// - index 0x61 holds codes 0x04 to 0x07, lowest code in bits 1-0
// - index 0x62 holds codes 0x08 to 0x0B, lowest code in bits 1-0
// - index 0x63 bits 7-6 give the priority of code 0x0F
// - every field is read/write and resets to 00
// - codes from 0x10 continue from index 0x64 in the same layout
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "dpm_consts.svh"

module dpm_priority_map (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // avalon-mm slave, byte addressed
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // classification request and answer
  input wire dpm_pkg::dpm_req_t cls_req,
  output dpm_pkg::dpm_rsp_t cls_rsp
);
  import dpm_pkg::*;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [`DPM_REG_W-1:0] map_q [`DPM_NUM_REGS];
  logic [7:0] reg_idx;
  logic hit;
  logic [3:0] sel;
  logic wr_fire;
  dpm_bus_state_t bus_q;

  assign reg_idx = avs_address[9:2];
  assign hit = (reg_idx >= `DPM_IDX_MAP_0) && (reg_idx <= `DPM_IDX_LAST);
  assign sel = 4'(reg_idx - `DPM_IDX_MAP_0);
  // write lands only on the edge where waitrequest is seen low
  assign wr_fire = (bus_q == DPM_BUS_DONE) && avs_write && hit && avs_byteenable[0];

  // one generate loop covers 0x60..0x63 and the run from 0x64 upward
  genvar r;
  generate
    for (r = 0; r < `DPM_NUM_REGS; r++) begin : g_reg
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          map_q[r] <= `DPM_REG_RESET;
        end else if (wr_fire && (sel == 4'(r))) begin
          map_q[r] <= avs_writedata[`DPM_REG_W-1:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, then completion
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_q <= DPM_BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      unique case (bus_q)
        DPM_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q <= DPM_BUS_DONE;
            avs_waitrequest <= 1'b0;
          end
        end
        DPM_BUS_DONE: begin
          bus_q <= DPM_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // unmapped reads answer zero; upper bits always zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (bus_q == DPM_BUS_IDLE && avs_read) begin
      avs_readdata <= hit ? {24'h00_0000, map_q[sel]} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // lookup
  // ----------------------------------------------------------------
  dpm_code_t code;
  logic [`DPM_NUM_CODES-1:0] onehot;
  logic [`DPM_FIELD_W-1:0] masked [`DPM_NUM_CODES];
  dpm_prio_t prio_sel;

  // ipv6 flag only travels along; no branch on it
  assign code = cls_req.tos[`DPM_CODE_MSB:`DPM_CODE_LSB];

  genvar c;
  generate
    for (c = 0; c < `DPM_NUM_CODES; c++) begin : g_code
      assign onehot[c] = (code == 6'(c));
      // field c sits in register c/4 at bits 2*(c%4)+1 : 2*(c%4)
      assign masked[c] = onehot[c] ? map_q[c / 4][2*(c % 4) +: 2] : 2'h0;
    end
  endgenerate

  always_comb begin
    prio_sel = 2'h0;
    for (int i = 0; i < `DPM_NUM_CODES; i++) begin
      prio_sel = prio_sel | masked[i];
    end
  end

  // table read uses state before this edge's write: same-cycle write affects next frame
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cls_rsp <= '0;
    end else begin
      cls_rsp.valid <= cls_req.valid;
      cls_rsp.ipv6 <= cls_req.ipv6;
      cls_rsp.code <= code;
      cls_rsp.prio <= cls_req.valid ? prio_sel : 2'h0;
    end
  end

endmodule // dpm_priority_map

`default_nettype wire

// >>> hdl/dpm_consts.svh
`ifndef DPM_CONSTS_SVH
`define DPM_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DPM_IDX_MAP_0 8'h60
`define DPM_IDX_MAP_1 8'h61
`define DPM_IDX_MAP_2 8'h62
`define DPM_IDX_MAP_3 8'h63
`define DPM_IDX_MAP_4 8'h64
`define DPM_IDX_LAST 8'h6F

// ----------------------------------------------------------------
// table geometry and reset values
// ----------------------------------------------------------------
`define DPM_NUM_REGS 16
`define DPM_NUM_CODES 64
`define DPM_FIELDS_PER_REG 4
`define DPM_FIELD_W 2
`define DPM_REG_W 8
`define DPM_REG_RESET 8'h00
`define DPM_CODE_LSB 2
`define DPM_CODE_MSB 7

`endif

// >>> hdl/dpm_pkg.sv
package dpm_pkg;

  typedef logic [1:0] dpm_prio_t;
  typedef logic [5:0] dpm_code_t;

  typedef struct packed {
    logic valid;
    logic ipv6;
    logic [7:0] tos;
  } dpm_req_t;

  typedef struct packed {
    logic valid;
    logic ipv6;
    dpm_code_t code;
    dpm_prio_t prio;
  } dpm_rsp_t;

  typedef enum logic [0:0] {
    DPM_BUS_IDLE,
    DPM_BUS_DONE
  } dpm_bus_state_t;

endpackage

// >>> verification/dpm_priority_map_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dpm_priority_map_sva (
  // clock, reset and bus
  input wire logic core_clk, arst_n, avs_read, avs_write, avs_waitrequest,
  input wire logic [9:0] avs_address,
  input wire logic [31:0] avs_writedata, avs_readdata,
  input wire logic [3:0] avs_byteenable,
  // lookup
  input wire dpm_pkg::dpm_req_t cls_req,
  input wire dpm_pkg::dpm_rsp_t cls_rsp
);
  import dpm_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  AST_CD: assert property (cls_req.valid |=> cls_rsp.code == $past(cls_req.tos[7:2]))
    else $error("code");
  AST_V6: assert property (cls_rsp.valid |-> cls_rsp.ipv6 == $past(cls_req.ipv6))
    else $error("ipv6");
  AST_NV: assert property (cls_rsp.valid == $past(cls_req.valid))
    else $error("valid");
  AST_ZP: assert property (!cls_rsp.valid |-> cls_rsp.prio == 2'h0)
    else $error("prio");
  AST_WT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait");
  AST_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("done");
  AST_UM: assert property (
    avs_read && avs_waitrequest && avs_address[9:6] != 4'h6 |=> avs_readdata == 32'h0)
    else $error("unmapped");
  AST_HI: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper");
  AST_ST: assert property (avs_waitrequest && !avs_read |=> $stable(avs_readdata))
    else $error("stand");
endmodule // dpm_priority_map_sva
bind dpm_priority_map dpm_priority_map_sva u_sva (.*);
`default_nettype wire

// >>> verification/dpm_priority_map_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dpm_priority_map_tb_top;
  import dpm_pkg::*;
  logic core_clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [7:0] i, mem [32] = '{default: 8'h00};
  dpm_req_t cls_req;
  dpm_rsp_t cls_rsp, eq;
  int err_count, checked;
  dpm_priority_map dut (.*);
  always #10 core_clk = ~core_clk;
  task automatic chk(string n, logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("Error %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // lane off sends inverted data, so a leak shows on readback
  task automatic bus(logic w, logic [7:0] a, logic be);
    @(posedge core_clk);
    {avs_address, avs_read, avs_write} <= {a, 2'h0, !w, w};
    {avs_writedata, avs_byteenable} <= {24'h0, mem[a[4:0]] ^ {8{!be}}, 3'h0, be};
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    if (!w) chk("rd", avs_readdata, {24'h0, a[4] ? 8'h00 : mem[a[3:0]]});
    {avs_read, avs_write} <= 2'h0;
  endtask
  always @(posedge core_clk) begin
    if (eq.valid === 1'b1)
      chk("rsp", 32'(cls_rsp), 32'(eq));
    eq <= {cls_req.valid, cls_req.ipv6, cls_req.tos[7:2],
      2'(mem[cls_req.tos[7:4]] >> {cls_req.tos[3:2], 1'b0})};
  end
  initial begin
    {core_clk, arst_n, cls_req, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    void'($urandom(32'hF54C2C74));
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    for (i = 8'h60; i < 8'h71; i++) begin
      bus(1'b0, i, 1'b1);
      mem[i[4:0]] = (i == 8'h63) ? 8'hC0 : 8'($urandom);
      bus(1'b1, i, 1'b1);
      bus(1'b0, i, 1'b1);
    end
    bus(1'b1, 8'h63, 1'b0);
    bus(1'b0, 8'h63, 1'b1);
    for (i = 0; i < 8'h80; i++) @(posedge core_clk) cls_req <= {1'b1, i[6], i[5:0], 2'($urandom)};
    @(posedge core_clk) cls_req <= '0;
    repeat (2) @(posedge core_clk);
    wrap_up;
  end
  initial begin
    #100000;
    err_count++;
    wrap_up;
  end
endmodule // dpm_priority_map_tb_top
`default_nettype wire
